// File: bank_mapper_map.svh
// Offsets, field positions, constants and codes of the program bank mapper
`ifndef BANK_MAPPER_MAP_SVH
`define BANK_MAPPER_MAP_SVH

// ---------------------------------------------------------------
// Address widths and field positions
// ---------------------------------------------------------------
`define LOG_ADDR_W      16
`define PHYS_ADDR_W     25
`define UPPER_W         12
`define PASS_MSB        12
`define LOW_PAGE_W      8
`define HIGH_PAGE_W     4
`define OVL_W           6

// ---------------------------------------------------------------
// Fixed page values and region bounds
// ---------------------------------------------------------------
`define PAGE_FIXED_FE   8'hFE
`define PAGE_ALL_ONES   8'hFF
`define GFX_FIRST       16'h2000
`define GFX_LAST        16'h20FF
`define BANKED_FIRST    16'h4000

// ---------------------------------------------------------------
// Overlay select codes and overlaid bit counts
// ---------------------------------------------------------------
`define OVL_SEL_TWO     3'h0
`define OVL_SEL_THREE   3'h1
`define OVL_SEL_FOUR    3'h2
`define OVL_SEL_FIVE    3'h3
`define OVL_SEL_SIX     3'h4
`define OVL_SEL_SIXB    3'h5
`define OVL_SEL_SIXC    3'h6
`define OVL_SEL_NONE    3'h7

`endif

// File: bank_mapper_pkg.sv
// Types shared by the program bank mapper files
package bank_mapper_pkg;

    // Logical 8 KB window picked by address bits 15..13
    typedef enum logic [2:0] {
        WIN_0 = 3'b000,
        WIN_1 = 3'b001,
        WIN_2 = 3'b010,
        WIN_3 = 3'b011,
        WIN_4 = 3'b100,
        WIN_5 = 3'b101,
        WIN_6 = 3'b110,
        WIN_7 = 3'b111
    } window_type;

    typedef logic [7:0] low_page_type;
    typedef logic [3:0] high_page_type;

endpackage

// File: page_overlay_stage.sv
// Second translation stage: overlays upper page bits from low page register 3
`include "bank_mapper_map.svh"

module page_overlay_stage
    import bank_mapper_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] overlaySelect,
    input  wire logic [5:0] pageHigh,
    input  wire logic [5:0] overlaySource,
    output logic      [5:0] pageOut
);

    // ---------------------------------------------------------------
    // Overlay width
    // ---------------------------------------------------------------
    logic [2:0] overlayCount;

    // Number of bits taken from the top of the source, counted from bit 20
    always_comb begin
        if (overlaySelect == `OVL_SEL_TWO) begin
            overlayCount = 3'h2;
        end else if (overlaySelect == `OVL_SEL_THREE) begin
            overlayCount = 3'h3;
        end else if (overlaySelect == `OVL_SEL_FOUR) begin
            overlayCount = 3'h4;
        end else if (overlaySelect == `OVL_SEL_FIVE) begin
            overlayCount = 3'h5;
        end else if (overlaySelect == `OVL_SEL_NONE) begin
            overlayCount = 3'h0;
        end else begin
            overlayCount = 3'h6;
        end
    end

    // ---------------------------------------------------------------
    // Per-bit multiplexer
    // ---------------------------------------------------------------
    // per-bit overlay choice
    genvar i;
    generate
        for (i = 0; i < `OVL_W; i++) begin : g_bit
            assign pageOut[`OVL_W-1-i] = (3'(i) < overlayCount) ?
                overlaySource[`OVL_W-1-i] : pageHigh[`OVL_W-1-i];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_ovl_none_pass: assert property (@(posedge sys_clk) disable iff (!rst_b)
        overlaySelect == `OVL_SEL_NONE |-> pageOut == pageHigh)
        else $error("overlay select 7 altered page bits");

    chk_ovl_two_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
        overlaySelect == `OVL_SEL_TWO |->
        pageOut == {overlaySource[5:4], pageHigh[3:0]})
        else $error("overlay select 0 wrong bit mix");

    chk_ovl_six_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
        overlaySelect == `OVL_SEL_SIX |-> pageOut == overlaySource)
        else $error("overlay select 4 did not take all six bits");

    cov_ovl_none: cover property (@(posedge sys_clk) disable iff (!rst_b)
        overlaySelect == `OVL_SEL_NONE);

endmodule // page_overlay_stage

// File: program_bank_address_mapper.sv
// Program bank mapper: 16-bit CPU logical address to 25-bit physical address
`include "bank_mapper_map.svh"

module program_bank_address_mapper
    import bank_mapper_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic [15:0]   logicalAddr,
    input  wire logic          quadBankEnable,
    input  wire logic          windowSwapSelect,
    input  wire logic          upperBankForce,
    input  wire logic [2:0]    lowBankOverlaySelect,
    input  wire low_page_type  lowPageReg0,
    input  wire low_page_type  lowPageReg1,
    input  wire low_page_type  lowPageReg2,
    input  wire low_page_type  lowPageReg3,
    input  wire low_page_type  lowPageReg4,
    input  wire low_page_type  lowPageReg5,
    input  wire high_page_type highPageReg0,
    input  wire high_page_type highPageReg1,
    input  wire high_page_type highPageReg2,
    input  wire high_page_type highPageReg3,
    input  wire high_page_type highPageReg4,
    input  wire high_page_type highPageReg5,
    output logic [24:0]        physicalAddr,
    output logic [11:0]        physicalUpperBits,
    output logic               bankedHit,
    output logic               graphicsPortHit,
    output logic               internalRegionHit
);

    // ---------------------------------------------------------------
    // Window decode
    // ---------------------------------------------------------------
    window_type    window;
    low_page_type  intermediatePageBits;
    high_page_type highPage;
    logic [5:0]    overlaidPage;

    assign window = window_type'(logicalAddr[15:13]);

    // banked space starts at window 010
    assign bankedHit = (logicalAddr >= `BANKED_FIRST);
    assign internalRegionHit = !bankedHit;

    assign graphicsPortHit = (logicalAddr >= `GFX_FIRST) && (logicalAddr <= `GFX_LAST);

    // ---------------------------------------------------------------
    // First stage: intermediate page bits 20..13
    // ---------------------------------------------------------------
    // low bank page selection
    always_comb begin
        intermediatePageBits = '0;
        case (window)
            WIN_2: intermediatePageBits = lowPageReg4;
            WIN_3: intermediatePageBits = lowPageReg5;
            WIN_4: begin
                case ({quadBankEnable, windowSwapSelect})
                    2'b00:   intermediatePageBits = lowPageReg0;
                    2'b01:   intermediatePageBits = `PAGE_FIXED_FE;
                    2'b10:   intermediatePageBits = lowPageReg0;
                    default: intermediatePageBits = lowPageReg2;
                endcase
            end
            WIN_5: intermediatePageBits = lowPageReg1;
            WIN_6: begin
                case ({quadBankEnable, windowSwapSelect})
                    2'b00:   intermediatePageBits = `PAGE_FIXED_FE;
                    2'b01:   intermediatePageBits = lowPageReg0;
                    2'b10:   intermediatePageBits = lowPageReg2;
                    default: intermediatePageBits = lowPageReg0;
                endcase
            end
            WIN_7: intermediatePageBits = `PAGE_ALL_ONES;
            // Internal RAM and ports see no substitution
            default: intermediatePageBits = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // Second stage: overlay from low page register 3
    // ---------------------------------------------------------------
    page_overlay_stage i_page_overlay_stage (
        .sys_clk       (sys_clk),
        .rst_b         (rst_b),
        .overlaySelect (lowBankOverlaySelect),
        .pageHigh      (intermediatePageBits[7:2]),
        .overlaySource (lowPageReg3[7:2]),
        .pageOut       (overlaidPage)
    );

    // ---------------------------------------------------------------
    // High bank: physical bits 24..21
    // ---------------------------------------------------------------
    // high bank page selection
    always_comb begin
        highPage = '0;
        case (window)
            WIN_2: highPage = highPageReg4;
            WIN_3: highPage = highPageReg5;
            WIN_4: begin
                if (upperBankForce) begin
                    highPage = highPageReg3;
                end else begin
                    case ({quadBankEnable, windowSwapSelect})
                        2'b00:   highPage = highPageReg0;
                        2'b01:   highPage = highPageReg3;
                        2'b10:   highPage = highPageReg0;
                        default: highPage = highPageReg2;
                    endcase
                end
            end
            WIN_5: highPage = upperBankForce ? highPageReg3 : highPageReg1;
            WIN_6: begin
                if (upperBankForce) begin
                    highPage = highPageReg3;
                end else begin
                    case ({quadBankEnable, windowSwapSelect})
                        2'b00:   highPage = highPageReg3;
                        2'b01:   highPage = highPageReg0;
                        2'b10:   highPage = highPageReg2;
                        default: highPage = highPageReg0;
                    endcase
                end
            end
            WIN_7: highPage = highPageReg3;
            default: highPage = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // Output assembly
    // ---------------------------------------------------------------
    // purely combinational so the CPU sees no added wait state
    // below the banked space the upper bits stay zero
    assign physicalUpperBits = bankedHit ?
        {highPage, overlaidPage, intermediatePageBits[1:0]} : '0;

    // upper bits joined to the untouched low bits
    assign physicalAddr = {physicalUpperBits, logicalAddr[`PASS_MSB:0]};

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_low_bits_pass: assert property (
        physicalAddr[12:0] == logicalAddr[12:0] && physicalAddr[24:13] == physicalUpperBits)
        else $error("low address bits not passed through");

    chk_fixed_windows: assert property (
        window == WIN_3 && lowBankOverlaySelect == `OVL_SEL_NONE
        |-> physicalAddr[20:13] == lowPageReg5)
        else $error("window 3 did not use low page register 5");

    chk_plain_map: assert property (
        window == WIN_6 && !quadBankEnable && !windowSwapSelect
        |-> intermediatePageBits == `PAGE_FIXED_FE)
        else $error("plain mode window 6 not FE");

    chk_swap_map: assert property (
        window == WIN_6 && !quadBankEnable && windowSwapSelect
        |-> intermediatePageBits == lowPageReg0)
        else $error("swap mode window 6 not register 0");

    chk_quad_map: assert property (
        window == WIN_6 && quadBankEnable && !windowSwapSelect
        |-> intermediatePageBits == lowPageReg2)
        else $error("quad mode window 6 not register 2");

    chk_quad_swap_map: assert property (
        window == WIN_4 && quadBankEnable && windowSwapSelect
        |-> intermediatePageBits == lowPageReg2)
        else $error("quad swap window 4 not register 2");

    chk_force_upper: assert property (
        upperBankForce && logicalAddr[15] |-> physicalAddr[24:21] == highPageReg3)
        else $error("upper force ignored");

    chk_high_plain: assert property (
        window == WIN_5 && !upperBankForce |-> physicalAddr[24:21] == highPageReg1)
        else $error("window 5 high page not register 1");

    chk_high_swap: assert property (
        window == WIN_4 && !upperBankForce && !quadBankEnable && windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg3)
        else $error("swap window 4 high page not register 3");

    chk_high_quad: assert property (
        window == WIN_6 && !upperBankForce && quadBankEnable && !windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg2)
        else $error("quad window 6 high page not register 2");

    chk_high_qswap: assert property (
        window == WIN_6 && !upperBankForce && quadBankEnable && windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg0)
        else $error("quad swap window 6 high page not register 0");

    chk_gfx_region: assert property (
        graphicsPortHit |-> physicalAddr == {12'h000, logicalAddr[12:0]})
        else $error("graphics region relocated");

    chk_high_fixed: assert property (
        window == WIN_2 |-> physicalAddr[24:21] == highPageReg4)
        else $error("window 2 high page not register 4");

    chk_internal_bypass: assert property (
        !logicalAddr[15] && !logicalAddr[14] |-> physicalAddr[24:13] == 12'h000)
        else $error("internal region got page bits");

    chk_same_cycle: assert property (
        $changed(lowPageReg1) && window == WIN_5 && lowBankOverlaySelect == `OVL_SEL_NONE
        |-> physicalAddr[20:13] == lowPageReg1)
        else $error("translation lagged register change");

    chk_banked_flag: assert property (
        bankedHit == (logicalAddr[15:14] != 2'h0) && internalRegionHit == !bankedHit)
        else $error("banked region flags wrong");

    chk_low_window2: assert property (
        window == WIN_2 && lowBankOverlaySelect == `OVL_SEL_NONE
        |-> physicalAddr[20:13] == lowPageReg4)
        else $error("window 2 did not use low page register 4");

    chk_plain_win4: assert property (
        window == WIN_4 && !quadBankEnable && !windowSwapSelect
        |-> intermediatePageBits == lowPageReg0)
        else $error("plain mode window 4 not register 0");

    chk_swap_win4: assert property (
        window == WIN_4 && !quadBankEnable && windowSwapSelect
        |-> intermediatePageBits == `PAGE_FIXED_FE)
        else $error("swap mode window 4 not FE");

    chk_top_ones: assert property (
        window == WIN_7 |-> intermediatePageBits == `PAGE_ALL_ONES)
        else $error("window 7 page bits not all ones");

    chk_win5_reg1: assert property (
        window == WIN_5 |-> intermediatePageBits == lowPageReg1)
        else $error("window 5 not low page register 1");

    // Overlay checked at the pins, so a wrong hookup of the stage shows up here
    chk_ovl_none_phys: assert property (
        lowBankOverlaySelect == `OVL_SEL_NONE && bankedHit
        |-> physicalAddr[20:13] == intermediatePageBits)
        else $error("overlay select 7 changed physical page bits");

    chk_ovl_two_phys: assert property (
        lowBankOverlaySelect == `OVL_SEL_TWO && bankedHit
        |-> physicalAddr[20:19] == lowPageReg3[7:6]
            && physicalAddr[18:13] == intermediatePageBits[5:0])
        else $error("overlay select 0 wrong physical bits");

    chk_ovl_six_phys: assert property (
        lowBankOverlaySelect == `OVL_SEL_SIX && bankedHit
        |-> physicalAddr[20:15] == lowPageReg3[7:2]
            && physicalAddr[14:13] == intermediatePageBits[1:0])
        else $error("overlay select 4 wrong physical bits");

    chk_high_plain_w6: assert property (
        window == WIN_6 && !upperBankForce && !quadBankEnable && !windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg3)
        else $error("plain window 6 high page not register 3");

    chk_high_swap_w6: assert property (
        window == WIN_6 && !upperBankForce && !quadBankEnable && windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg0)
        else $error("swap window 6 high page not register 0");

    chk_high_quad_w4: assert property (
        window == WIN_4 && !upperBankForce && quadBankEnable && !windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg0)
        else $error("quad window 4 high page not register 0");

    chk_high_qswap_w4: assert property (
        window == WIN_4 && !upperBankForce && quadBankEnable && windowSwapSelect
        |-> physicalAddr[24:21] == highPageReg2)
        else $error("quad swap window 4 high page not register 2");

    chk_high_top: assert property (
        window == WIN_7 |-> physicalAddr[24:21] == highPageReg3)
        else $error("window 7 high page not register 3");

    chk_high_window3: assert property (
        window == WIN_3 |-> physicalAddr[24:21] == highPageReg5)
        else $error("window 3 high page not register 5");

    chk_gfx_decode: assert property (
        graphicsPortHit == (logicalAddr[15:8] == 8'h20))
        else $error("graphics port decode wrong");

    cov_quad_swap: cover property (quadBankEnable && windowSwapSelect && window == WIN_4);
    cov_force: cover property (upperBankForce && window == WIN_6);
    cov_gfx: cover property (graphicsPortHit ##1 bankedHit);

endmodule // program_bank_address_mapper

// File: cpu_addr_model.sv
// CPU-side model that presents logical addresses to the program bank mapper
module cpu_addr_model
    import bank_mapper_pkg::*;
(
    output logic [15:0] logicalAddr
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Address bus of the CPU core
    // ---------------------------------------------------------------
    // The core never floats its address bus, so start from a defined value
    initial begin
        logicalAddr = 16'h0000;
    end

    // Caller launches this just after a rising edge; the address then stands all cycle
    task automatic issue(input logic [15:0] addr);
        logicalAddr = addr;
    endtask

endmodule // cpu_addr_model

// File: tb_program_bank_address_mapper.sv
// Self-checking testbench of the program bank address mapper
`include "bank_mapper_map.svh"

module tb_program_bank_address_mapper
    import bank_mapper_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Stimulus and observation signals
    // ---------------------------------------------------------------
    logic          sys_clk;
    logic          rst_b;
    logic [15:0]   logicalAddr;
    logic          quadBankEnable;
    logic          windowSwapSelect;
    logic          upperBankForce;
    logic [2:0]    lowBankOverlaySelect;
    low_page_type  lp [6];
    high_page_type hp [6];
    logic [24:0]   physicalAddr;
    logic [11:0]   physicalUpperBits;
    logic          bankedHit;
    logic          graphicsPortHit;
    logic          internalRegionHit;
    int            nMismatch;
    int            samplesChecked;
    integer        seed;

    // Page source per {quad, swap} and window 4..7: 0..2 register, 6 is FE, 7 is FF
    localparam logic [2:0] LOW_SEL [4][4] = '{'{3'h0, 3'h1, 3'h6, 3'h7},
                                             '{3'h6, 3'h1, 3'h0, 3'h7},
                                             '{3'h0, 3'h1, 3'h2, 3'h7},
                                             '{3'h2, 3'h1, 3'h0, 3'h7}};
    localparam logic [2:0] HIGH_SEL [4][4] = '{'{3'h0, 3'h1, 3'h3, 3'h3},
                                              '{3'h3, 3'h1, 3'h0, 3'h3},
                                              '{3'h0, 3'h1, 3'h2, 3'h3},
                                              '{3'h2, 3'h1, 3'h0, 3'h3}};
    // Number of bits taken from low page register 3, counted down from bit 20
    localparam int OVL_CNT [8] = '{2, 3, 4, 5, 6, 6, 6, 0};

    // ---------------------------------------------------------------
    // Design and CPU model
    // ---------------------------------------------------------------
    program_bank_address_mapper i_program_bank_address_mapper (
        .sys_clk              (sys_clk),
        .rst_b                (rst_b),
        .logicalAddr          (logicalAddr),
        .quadBankEnable       (quadBankEnable),
        .windowSwapSelect     (windowSwapSelect),
        .upperBankForce       (upperBankForce),
        .lowBankOverlaySelect (lowBankOverlaySelect),
        .lowPageReg0          (lp[0]),
        .lowPageReg1          (lp[1]),
        .lowPageReg2          (lp[2]),
        .lowPageReg3          (lp[3]),
        .lowPageReg4          (lp[4]),
        .lowPageReg5          (lp[5]),
        .highPageReg0         (hp[0]),
        .highPageReg1         (hp[1]),
        .highPageReg2         (hp[2]),
        .highPageReg3         (hp[3]),
        .highPageReg4         (hp[4]),
        .highPageReg5         (hp[5]),
        .physicalAddr         (physicalAddr),
        .physicalUpperBits    (physicalUpperBits),
        .bankedHit            (bankedHit),
        .graphicsPortHit      (graphicsPortHit),
        .internalRegionHit    (internalRegionHit)
    );

    cpu_addr_model i_cpu_addr_model (
        .logicalAddr (logicalAddr)
    );

    // ---------------------------------------------------------------
    // Expected translation
    // ---------------------------------------------------------------
    // Works from the bench's own copy of the modes and page values
    function automatic logic [11:0] expUpper(input logic [15:0] a);
        logic [2:0] w;
        logic [1:0] m;
        logic [2:0] lo;
        logic [7:0] tp;
        logic [3:0] hb;
        w = a[15:13];
        m = {quadBankEnable, windowSwapSelect};
        if (w[2:1] == 2'b00) return 12'h000;
        if (!w[2]) begin
            tp = lp[4 + w[0]];
            hb = hp[4 + w[0]];
        end else begin
            lo = LOW_SEL[m][w[1:0]];
            tp = (lo == 3'h6) ? `PAGE_FIXED_FE : (lo == 3'h7) ? `PAGE_ALL_ONES : lp[lo];
            hb = upperBankForce ? hp[3] : hp[HIGH_SEL[m][w[1:0]]];
        end
        for (int k = 0; k < OVL_CNT[lowBankOverlaySelect]; k++) tp[7 - k] = lp[3][7 - k];
        return {hb, tp};
    endfunction

    // ---------------------------------------------------------------
    // Checking and closing
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One cycle: drive just after the edge, compare at the falling edge of that cycle
    task automatic drive(input logic [5:0] mode, input logic [15:0] a);
        @(posedge sys_clk);
        #1;
        {quadBankEnable, windowSwapSelect, upperBankForce, lowBankOverlaySelect} = mode;
        for (int i = 0; i < 6; i++) begin
            lp[i] = low_page_type'($random(seed));
            hp[i] = high_page_type'($random(seed));
        end
        i_cpu_addr_model.issue(a);
        @(negedge sys_clk);
        check({7'h00, physicalAddr}, {7'h00, expUpper(a), a[12:0]});
        check({20'h00000, physicalUpperBits}, {20'h00000, expUpper(a)});
        check({31'h0, bankedHit}, {31'h0, a >= `BANKED_FIRST});
        check({31'h0, graphicsPortHit}, {31'h0, a >= `GFX_FIRST && a <= `GFX_LAST});
        check({31'h0, internalRegionHit}, {31'h0, a < `BANKED_FIRST});
    endtask

    // ---------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ---------------------------------------------------------------
    // Free-running 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Whole run needs about a thousand cycles; five thousand means a hang
    initial begin
        #40000;
        nMismatch++;
        complete_run;
    end

    // Full mode sweep, region boundaries, then random traffic
    initial begin
        logic [15:0] corner [10];
        corner = '{16'h0000, 16'h1FFF, 16'h2000, 16'h20FF, 16'h2100,
                   16'h3FFF, 16'h4000, 16'h5FFF, 16'h8000, 16'hFFFF};
        rst_b = 1'b0;
        quadBankEnable = 1'b0;
        windowSwapSelect = 1'b0;
        upperBankForce = 1'b0;
        lowBankOverlaySelect = 3'h0;
        lp = '{default: 8'h00};
        hp = '{default: 4'h0};
        seed = 32'h580A;
        nMismatch = 0;
        samplesChecked = 0;
        repeat (4) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        for (int m = 0; m < 64; m++) begin
            for (int w = 0; w < 8; w++) begin
                drive(6'(m), {3'(w), 13'($random(seed))});
            end
        end
        foreach (corner[i]) begin
            drive(6'($random(seed)), corner[i]);
        end
        repeat (400) begin
            drive(6'($random(seed)), 16'($random(seed)));
        end
        complete_run;
    end

endmodule // tb_program_bank_address_mapper
